// File: rtl/gpr_defs.vh
// Register map, field positions and reset values of the pin router.
// Assumes byte addresses on an APB bus with 32-bit data.
`ifndef GPR_DEFS_VH
`define GPR_DEFS_VH

`define GPR_OFS_DEBOUNCE   8'h70
`define GPR_OFS_ROUTE_A    8'h80
`define GPR_OFS_ROUTE_B    8'h84
`define GPR_OFS_ROUTE_C    8'h88
`define GPR_OFS_EDGE_A     8'h90
`define GPR_OFS_EDGE_B     8'h94
`define GPR_OFS_EDGE_C     8'h98
`define GPR_OFS_LWSEL      8'hA0
`define GPR_OFS_SNAP_A     8'hA4
`define GPR_OFS_SNAP_B     8'hA8
`define GPR_OFS_SNAP_C     8'hAC
`define GPR_OFS_TRIG_AB    8'hB4
`define GPR_OFS_TRIG_C     8'hB8

`define GPR_RST_ROUTE_A    32'h00000000
`define GPR_RST_ROUTE_B    32'h00055555
`define GPR_RST_ROUTE_C    32'h002AAAAA
`define GPR_RST_ZERO       32'h00000000

`define GPR_MASK_ROUTE_B   32'h000FFFFF
`define GPR_MASK_ROUTE_C   32'h003FFFFF
`define GPR_MASK_EDGE_B    32'h03FF03FF
`define GPR_MASK_EDGE_C    32'h07FF07FF
`define GPR_MASK_LWSEL     32'h000001FF
`define GPR_MASK_DEBOUNCE  32'h000000FF

`define GPR_RISE_LSB       16
`define GPR_HOLD_BIT       8
`define GPR_WAKE_LSB       4
`define GPR_DBRATE_LSB     4

`endif

// File: rtl/gpr_debounce.v
// Periodic-sampling input filter with its own rate divider.
// Assumes din is already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none

module gpr_debounce #(
   parameter WIDTH = 37
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire [3:0]       rate,
   input  wire [WIDTH-1:0] filt_mask,
   input  wire [WIDTH-1:0] din,
   output reg  [WIDTH-1:0] dout
);

   reg  [14:0] cnt;
   wire [14:0] lim;
   wire        tick;

   // Sample once per 2^rate clocks
   assign lim  = ~({15{1'b1}} << rate);
   assign tick = (cnt & lim) == lim;

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt <= 15'h0000;
      else
         cnt <= cnt + 15'h0001;
   end

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         dout <= {WIDTH{1'b0}};
      else
         dout <= (din & ~filt_mask) | ((tick ? din : dout) & filt_mask);
   end

endmodule

`default_nettype wire

// File: rtl/gpr_router.v
// Pin interrupt router: edge detect, line routing, snapshot and wake.
// Assumes an APB master on pclk; pins are asynchronous to pclk.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "gpr_defs.vh"

// Functional notes
// - Port C two-bit routing field per pin
// - Field value selects line zero to three
// - Port C routing resets to line two
// - Low half bits enable falling edges
// - Bits x+16 enable rising edges
// - Both enables trigger on either edge
// - B and C use own routing registers
// - Wake pins act as level conditions
// - Both enables give high wake level
// - Bits 7..4 enable wake per line
// - Bits 3..0 enable snapshot per line
// - Port A snapshot returns captured pins
// - Edge enables clear at reset
// - Trigger flags set on edge, W1C
// - Flags capture regardless of pin direction
// - Per-line debounce by periodic sampling
module gpr_router #(
   parameter NA = 16,
   parameter NB = 10,
   parameter NC = 11
) (
   input  wire          pclk,
   input  wire          presetn,
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [7:0]    paddr,
   input  wire [31:0]   pwdata,
   output reg  [31:0]   prdata,
   output wire          pready,
   output wire          pslverr,
   input  wire [NA-1:0] porta_pin,
   input  wire [NB-1:0] portb_pin,
   input  wire [NC-1:0] portc_pin,
   output reg  [3:0]    irq_line,
   output reg           pd_wake
);

   // All pins as one vector: port A low, then B, then C
   localparam NP = NA + NB + NC;

   ////////////////////////////////////////////////////////////////////
   // Registers

   reg  [31:0] porta_irq_routing;
   reg  [31:0] portb_irq_routing;
   reg  [31:0] portc_irq_routing;
   reg  [31:0] porta_edge_enable;
   reg  [31:0] portb_edge_enable;
   reg  [31:0] portc_edge_enable;
   reg  [8:0]  latch_wake_select;
   reg  [7:0]  debounce_ctrl;
   reg  [NP-1:0] snapshot;
   reg  [NP-1:0] trig_flag;

   wire        wr_en;
   wire        rd_setup;
   wire [31:0] wmask_ab;
   wire [31:0] wmask_c;
   reg  [31:0] next_rdata;
   reg         mapped;

   wire        line_hold_mode;
   wire [3:0]  line_wake_enable;
   wire [3:0]  line_snapshot_enable;
   wire [3:0]  line_debounce_enable;

   assign line_hold_mode       = latch_wake_select[`GPR_HOLD_BIT];
   assign line_wake_enable     = latch_wake_select[7:4];
   assign line_snapshot_enable = latch_wake_select[3:0];
   assign line_debounce_enable = debounce_ctrl[3:0];

   ////////////////////////////////////////////////////////////////////
   // APB slave: zero wait states, error on unmapped address

   // Writes land in the access cycle; reads load prdata at setup
   assign wr_en    = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign pready   = 1'b1;

   // Known offsets; anything else answers with an error
   always @*
   begin
      mapped = 1'b1;
      case (paddr)
         `GPR_OFS_DEBOUNCE, `GPR_OFS_ROUTE_A, `GPR_OFS_ROUTE_B,
         `GPR_OFS_ROUTE_C, `GPR_OFS_EDGE_A, `GPR_OFS_EDGE_B,
         `GPR_OFS_EDGE_C, `GPR_OFS_LWSEL, `GPR_OFS_SNAP_A,
         `GPR_OFS_SNAP_B, `GPR_OFS_SNAP_C, `GPR_OFS_TRIG_AB,
         `GPR_OFS_TRIG_C:
            mapped = 1'b1;
         default:
            mapped = 1'b0;
      endcase
   end

   assign pslverr = psel & penable & ~mapped;

   // Read data: unused bits stay zero
   always @*
   begin
      next_rdata = 32'h00000000;
      case (paddr)
         `GPR_OFS_DEBOUNCE: next_rdata[7:0] = debounce_ctrl;
         `GPR_OFS_ROUTE_A:  next_rdata = porta_irq_routing;
         `GPR_OFS_ROUTE_B:  next_rdata = portb_irq_routing;
         `GPR_OFS_ROUTE_C:  next_rdata = portc_irq_routing;
         `GPR_OFS_EDGE_A:   next_rdata = porta_edge_enable;
         `GPR_OFS_EDGE_B:   next_rdata = portb_edge_enable;
         `GPR_OFS_EDGE_C:   next_rdata = portc_edge_enable;
         `GPR_OFS_LWSEL:    next_rdata[8:0] = latch_wake_select;
         `GPR_OFS_SNAP_A:   next_rdata[NA-1:0] = snapshot[NA-1:0];
         `GPR_OFS_SNAP_B:   next_rdata[NB-1:0] = snapshot[NA+NB-1:NA];
         `GPR_OFS_SNAP_C:   next_rdata[NC-1:0] = snapshot[NP-1:NA+NB];
         // Flags: port A in 15:0, port B in 25:16
         `GPR_OFS_TRIG_AB:
         begin
            next_rdata[NA-1:0] = trig_flag[NA-1:0];
            next_rdata[16+NB-1:16] = trig_flag[NA+NB-1:NA];
         end
         `GPR_OFS_TRIG_C:   next_rdata[NC-1:0] = trig_flag[NP-1:NA+NB];
         default:           next_rdata = 32'h00000000;
      endcase
   end

   // Loaded in the setup cycle, stands through the access cycle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (rd_setup)
         prdata <= next_rdata;
   end

   // Writable registers, reserved bits masked
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         porta_irq_routing <= `GPR_RST_ROUTE_A;
         portb_irq_routing <= `GPR_RST_ROUTE_B;
         portc_irq_routing <= `GPR_RST_ROUTE_C;
         porta_edge_enable <= `GPR_RST_ZERO;
         portb_edge_enable <= `GPR_RST_ZERO;
         portc_edge_enable <= `GPR_RST_ZERO;
         latch_wake_select <= 9'h000;
         debounce_ctrl     <= 8'h00;
      end
      else if (wr_en)
      begin
         case (paddr)
            `GPR_OFS_DEBOUNCE:
               debounce_ctrl <= pwdata[7:0];
            `GPR_OFS_ROUTE_A:
               porta_irq_routing <= pwdata;
            `GPR_OFS_ROUTE_B:
               portb_irq_routing <= pwdata & `GPR_MASK_ROUTE_B;
            `GPR_OFS_ROUTE_C:
               portc_irq_routing <= pwdata & `GPR_MASK_ROUTE_C;
            `GPR_OFS_EDGE_A:
               porta_edge_enable <= pwdata;
            `GPR_OFS_EDGE_B:
               portb_edge_enable <= pwdata & `GPR_MASK_EDGE_B;
            `GPR_OFS_EDGE_C:
               portc_edge_enable <= pwdata & `GPR_MASK_EDGE_C;
            `GPR_OFS_LWSEL:
               latch_wake_select <= pwdata[8:0];
            default:
               debounce_ctrl <= debounce_ctrl;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers and debounce

   reg  [NP-1:0] pin_meta;
   reg  [NP-1:0] pin_sync;
   wire [NP-1:0] pin_filt;
   reg  [NP-1:0] pin_prev;
   wire [NP-1:0] filt_mask;

   // Two flops per pin; only the second one is read
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_meta <= {NP{1'b0}};
         pin_sync <= {NP{1'b0}};
      end
      else
      begin
         pin_meta <= {portc_pin, portb_pin, porta_pin};
         pin_sync <= pin_meta;
      end
   end

   // Bypassed lines still pass its output register
   gpr_debounce #(
      .WIDTH (NP)
   ) i_gpr_debounce (
      .clk       (pclk),
      .rst_n     (presetn),
      .rate      (debounce_ctrl[7:4]),
      .filt_mask (filt_mask),
      .din       (pin_sync),
      .dout      (pin_filt)
   );

   // Previous filtered sample for edge compare
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pin_prev <= {NP{1'b0}};
      else
         pin_prev <= pin_filt;
   end

   ////////////////////////////////////////////////////////////////////
   // Per-pin routing, edge events and wake levels

   wire [2*NP-1:0] route_all;
   wire [NP-1:0]   fall_en;
   wire [NP-1:0]   rise_en;
   wire [NP-1:0]   pin_evt;
   wire [NP-1:0]   wake_lvl;
   wire [4*NP-1:0] hit;

   // Port B and C pins take their line from their own routing
   assign route_all = {portc_irq_routing[2*NC-1:0],
                       portb_irq_routing[2*NB-1:0],
                       porta_irq_routing[2*NA-1:0]};
   assign fall_en = {portc_edge_enable[NC-1:0],
                     portb_edge_enable[NB-1:0],
                     porta_edge_enable[NA-1:0]};
   assign rise_en = {portc_edge_enable[`GPR_RISE_LSB+NC-1:`GPR_RISE_LSB],
                     portb_edge_enable[`GPR_RISE_LSB+NB-1:`GPR_RISE_LSB],
                     porta_edge_enable[`GPR_RISE_LSB+NA-1:`GPR_RISE_LSB]};

   // hit[l*NP+i] is high when pin i feeds line l
   genvar i;
   genvar l;
   generate
      for (i = 0; i < NP; i = i + 1)
      begin : g_pin
         wire [1:0] sel;
         assign sel = route_all[2*i+1:2*i];
         for (l = 0; l < 4; l = l + 1)
         begin : g_line
            assign hit[l*NP+i] = ({30'h00000000, sel} == l);
         end
         assign filt_mask[i] = line_debounce_enable[sel];
         // Either enabled edge fires; pin direction is not looked at
         assign pin_evt[i] =
            (fall_en[i] & pin_prev[i] & ~pin_filt[i]) |
            (rise_en[i] & ~pin_prev[i] & pin_filt[i]);
         // Rise or both: high wakes; fall only: low wakes
         assign wake_lvl[i] = rise_en[i] ? pin_filt[i] :
                              (fall_en[i] & ~pin_filt[i]);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Trigger flags: hardware set wins over write-one clear

   wire [NP-1:0] flag_clr;

   // Write-one masks per port field; other writes clear nothing
   assign flag_clr[NA-1:0] =
      (wr_en && paddr == `GPR_OFS_TRIG_AB) ? pwdata[NA-1:0] : {NA{1'b0}};
   assign flag_clr[NA+NB-1:NA] =
      (wr_en && paddr == `GPR_OFS_TRIG_AB) ? pwdata[16+NB-1:16]
                                           : {NB{1'b0}};
   assign flag_clr[NP-1:NA+NB] =
      (wr_en && paddr == `GPR_OFS_TRIG_C) ? pwdata[NC-1:0] : {NC{1'b0}};

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         trig_flag <= {NP{1'b0}};
      else
         // Clear and new edge in one cycle: flag stays set
         trig_flag <= (trig_flag & ~flag_clr) | pin_evt;
   end

   ////////////////////////////////////////////////////////////////////
   // Interrupt lines, snapshot and wake

   wire [3:0] line_evt;
   wire [3:0] line_lvl;
   wire [3:0] line_wake;
   wire [3:0] next_irq;

   // Per-line views of events, flags and wake levels
   generate
      for (l = 0; l < 4; l = l + 1)
      begin : g_out
         assign line_evt[l]  = |(pin_evt & hit[l*NP+NP-1:l*NP]);
         assign line_lvl[l]  = |(trig_flag & hit[l*NP+NP-1:l*NP]);
         assign line_wake[l] = line_wake_enable[l] &
                               |(wake_lvl & hit[l*NP+NP-1:l*NP]);
      end
   endgenerate

   // Pulse per event, or held until flags are cleared
   assign next_irq = line_hold_mode ? (line_lvl | line_evt)
                                    : line_evt;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_line <= 4'h0;
         pd_wake  <= 1'b0;
      end
      else
      begin
         // Wake is a level, not an event, so it is not latched
         irq_line <= next_irq;
         pd_wake  <= |line_wake;
      end
   end

   // All three ports captured together while a selected line is active
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         snapshot <= {NP{1'b0}};
      else if (|(irq_line & line_snapshot_enable))
         snapshot <= pin_sync;
   end

endmodule

`default_nettype wire

// File: testbench/gpr_router_chk.sv
// Port checker for the pin router.
// Assumes one pclk domain; bound to every router instance.
`timescale 1ns/1ps
`default_nettype none
module gpr_router_chk (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pslverr,
   input wire [3:0]  irq_line,
   input wire        pd_wake
);
   wire acc = psel && penable;
   wire wr = acc && pwrite;
   wire wr_lw = wr && paddr == 8'hA0;
   wire mapped = paddr inside {8'h70, 8'h80, 8'h84, 8'h88, 8'h90, 8'h94,
      8'h98, 8'hA0, 8'hA4, 8'hA8, 8'hAC, 8'hB4, 8'hB8};
   reg  [8:4] lw;
   // Shadow of hold and wake bits
   always @(posedge pclk or negedge presetn)
      if (!presetn)
         lw <= 5'h00;
      else if (wr_lw)
         lw <= pwdata[8:4];
////////////////////////////////////////
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   err_unmapped_a: assert property (acc && !mapped |-> pslverr)
      else $error("no error on unmapped access");
   err_mapped_a: assert property (acc && mapped |-> !pslverr)
      else $error("error on mapped access");
   rd_unmapped_a: assert property (psel && !penable && !pwrite && !mapped
      |=> prdata == 32'h00000000) else $error("unmapped read not zero");
   route_res_a: assert property (acc && !pwrite && paddr == 8'h88
      |-> prdata[31:22] == 10'h000) else $error("routing reserved bits set");
   edge_res_a: assert property (acc && !pwrite && paddr == 8'h94
      |-> (prdata & 32'hFC00FC00) == 32'h0) else $error("edge bits set");
   pulse_one_a: assert property (!lw[8] && irq_line != 4'h0 && !wr
      |=> (irq_line & $past(irq_line)) == 4'h0) else $error("pulse too long");
   hold_keep_a: assert property (lw[8] && !wr && !$past(wr)
      |=> (irq_line & $past(irq_line)) == $past(irq_line))
      else $error("held line dropped");
   wake_off_a: assert property (lw[7:4] == 4'h0 && !wr_lw |=> !pd_wake)
      else $error("wake without enable");
endmodule
bind gpr_router gpr_router_chk i_gpr_router_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
   .irq_line(irq_line), .pd_wake(pd_wake));
`default_nettype wire

// File: testbench/gpr_irq_sink.sv
// Far-side model: interrupt controller and wake logic.
// Assumes lines and wake are synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module gpr_irq_sink (
   input  wire        pclk,
   input  wire        presetn,
   input  wire [3:0]  irq_line,
   input  wire        pd_wake,
   output logic [7:0] rise_cnt,
   output logic       woke
);
   logic [3:0] last;
   // Controller reacts to rising line edges only
   always @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         rise_cnt <= 8'h00;
         last <= 4'h0;
         woke <= 1'b0;
      end
      else
      begin
         if ((irq_line & ~last) != 4'h0)
            rise_cnt <= rise_cnt + 8'h01;
         last <= irq_line;
         woke <= pd_wake;
      end
endmodule
`default_nettype wire

// File: testbench/tb_gpio_pin_interrupt_router.sv
// Self-checking bench for the pin router.
// Assumes a zero-wait APB slave; debounce stays off until t_deb.
`timescale 1ns/1ps
`default_nettype none
module tb_gpio_pin_interrupt_router;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [15:0] pa = 16'h0;
   logic [9:0]  pb = 10'h0;
   logic [10:0] pc = 11'h0;
   wire  [31:0] prdata;
   wire         pready;
   wire         pslverr;
   wire  [3:0]  irq_line;
   wire         pd_wake;
   wire  [7:0]  rise_cnt;
   wire         woke;
   int          fail_count = 0;
   int          cmp_count = 0;
   logic [31:0] rd;
   logic        er;
   gpr_router i_gpr_router (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .porta_pin(pa),
      .portb_pin(pb), .portc_pin(pc), .irq_line(irq_line), .pd_wake(pd_wake));
   gpr_irq_sink i_gpr_irq_sink (.pclk(pclk), .presetn(presetn),
      .irq_line(irq_line), .pd_wake(pd_wake), .rise_cnt(rise_cnt),
      .woke(woke));
   initial
      forever #12.5 pclk = ~pclk;
////////////////////////////////////////
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 16)
      begin
         fail_count++;
         report_and_stop;
      end
   endtask
   task automatic wait_for(input string n, input logic w, input logic [3:0] e);
      int k;
      logic [3:0] g;
      for (k = 0; k < 12; k++)
      begin
         @(posedge pclk);
         g = w ? {3'h0, woke} : irq_line;
         if (g === e)
            break;
      end
      chk(n, {28'h0, e}, {28'h0, g});
      if (k == 12)
         report_and_stop;
   endtask
   task automatic quiet(input string n);
      logic [7:0] c;
      @(posedge pclk);
      c = rise_cnt;
      repeat (12) @(posedge pclk);
      chk(n, {24'h0, c}, {24'h0, rise_cnt});
   endtask
   task automatic t_regs;
      apb(1'b0, 8'h88, 32'h0);
      chk("route_c", 32'h002AAAAA, rd);
      apb(1'b0, 8'h90, 32'h0);
      chk("edge_a", 32'h0, rd);
      apb(1'b1, 8'h98, 32'hFFFFFFFF);
      apb(1'b0, 8'h98, 32'h0);
      chk("edge_c", 32'h07FF07FF, rd);
      apb(1'b1, 8'h88, 32'hFFFFFFFF);
      apb(1'b0, 8'h88, 32'h0);
      chk("route_c_w", 32'h003FFFFF, rd);
      apb(1'b0, 8'hFC, 32'h0);
      chk("unmapped", 32'h1, {31'h0, er});
      apb(1'b1, 8'h98, 32'h00080000);
      $display("t_regs done");
   endtask
   task automatic t_route;
      for (int v = 0; v < 4; v++)
      begin
         apb(1'b1, 8'h88, (32'h002AAAAA & ~32'hC0) | (v << 6));
         pc[3] <= 1'b1;
         wait_for("route", 1'b0, 4'h1 << v);
         pc[3] <= 1'b0;
         quiet("no_fall");
      end
      apb(1'b1, 8'h88, 32'h002AAAAA);
      $display("t_route done");
   endtask
   task automatic t_porta;
      apb(1'b1, 8'h90, 32'h20);
      pa[5] <= 1'b1;
      quiet("no_rise");
      pa[5] <= 1'b0;
      wait_for("fall", 1'b0, 4'h1);
      apb(1'b1, 8'h90, 32'h00200020);
      pa[5] <= 1'b1;
      wait_for("both_r", 1'b0, 4'h1);
      apb(1'b0, 8'hB4, 32'h0);
      chk("flag", 32'h20, rd);
      apb(1'b1, 8'hB4, 32'h20);
      apb(1'b0, 8'hB4, 32'h0);
      chk("flag_clr", 32'h0, rd);
      pa[5] <= 1'b0;
      wait_for("both_f", 1'b0, 4'h1);
      apb(1'b1, 8'h90, 32'h0);
      pb[9] <= 1'b1;
      quiet("off_b");
      apb(1'b1, 8'h94, 32'h02000000);
      pb[9] <= 1'b0;
      quiet("b_fall");
      pb[9] <= 1'b1;
      wait_for("route_b", 1'b0, 4'h2);
      $display("t_porta done");
   endtask
   task automatic t_hold;
      pa <= 16'hA5C3;
      apb(1'b1, 8'hB4, 32'h03FFFFFF);
      apb(1'b1, 8'hB8, 32'h7FF);
      apb(1'b1, 8'hA0, 32'h104);
      pc[3] <= 1'b1;
      wait_for("hold", 1'b0, 4'h4);
      repeat (6) @(posedge pclk);
      chk("held", 32'h4, {28'h0, irq_line});
      apb(1'b1, 8'hA4, 32'h0);
      apb(1'b0, 8'hA4, 32'h0);
      chk("snap", 32'hA5C3, rd);
      apb(1'b1, 8'hB8, 32'h8);
      wait_for("released", 1'b0, 4'h0);
      $display("t_hold done");
   endtask
   task automatic t_wake;
      apb(1'b1, 8'h90, 32'h00200000);
      apb(1'b1, 8'hA0, 32'h10);
      wait_for("wake_lo", 1'b1, 4'h0);
      pa[5] <= 1'b1;
      wait_for("wake_hi", 1'b1, 4'h1);
      apb(1'b1, 8'h90, 32'h20);
      wait_for("fall_lvl", 1'b1, 4'h0);
      apb(1'b1, 8'h90, 32'h00200020);
      wait_for("both_lvl", 1'b1, 4'h1);
      $display("t_wake done");
   endtask
   task automatic t_deb;
      apb(1'b1, 8'h70, 32'h21);
      apb(1'b0, 8'h70, 32'h0);
      chk("deb_ctrl", 32'h21, rd);
      pa[5] <= 1'b0;
      wait_for("deb_fall", 1'b0, 4'h1);
      $display("t_deb done");
   endtask
   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_route;
      t_porta;
      t_hold;
      t_wake;
      t_deb;
      report_and_stop;
   end
endmodule
`default_nettype wire
